// ===== verilog/ipq_pkg.sv
// constants, carriers and the length decoder of the instruction prefetch queue
// assumes one core clock; byte order in a fetched word is most significant byte first
package ipq_pkg;
  localparam int QB = 12; // byte entries in the queue
  localparam int WORD_BYTES = 4; // bytes in one fetched word
  localparam int BYTE_W = 8; // bits in one entry
  localparam int FIFO_DEPTH = 4; // words buffered between cache and queue
  localparam int CNT_W = 5; // width of byte counts
  localparam int ADDR_W = 32; // fetch address width
  localparam int INFL_W = 3; // width of outstanding fetch count
  localparam logic [2:0] LEN0 = 3'h0; // no bytes
  localparam logic [2:0] LEN1 = 3'h1; // one byte
  localparam logic [2:0] LEN2 = 3'h2; // two bytes
  localparam logic [2:0] LEN3 = 3'h3; // three bytes
  localparam logic [2:0] LEN4 = 3'h4; // four bytes
  localparam logic [2:0] RISC_EXT_TAG = 3'h7; // top opcode bits of an extended instruction
  localparam logic [7:0] JOP_BIPUSH = 8'h10; // bytecode with one operand byte
  localparam logic [7:0] JOP_SIPUSH = 8'h11; // bytecode with two operand bytes
  localparam logic [7:0] JOP_LDC = 8'h12; // bytecode with one operand byte
  localparam logic [1:0] ALIGN_WORD = 2'h0; // target on a word boundary
  localparam logic [1:0] ALIGN_HALF = 2'h2; // target on a halfword boundary
  localparam logic [1:0] ADDR_LOW0 = 2'h0; // low address bits of a fetch
  localparam logic [ADDR_W-1:0] FETCH_STEP = 32'h0000_0004; // fetch address increment
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000; // fetch address after reset

  // change-of-flow events that empty the queue
  typedef struct packed {
    logic exc_entry; // exception routine entered
    logic pc_write; // instruction wrote the program counter
    logic unpred_br; // unpredicted branch executed
    logic mispred; // misprediction detected
    logic ret_pop; // return address popped
  } ipq_flush_t;

  // one fetched word with the path tag it was requested under
  typedef struct packed {
    logic epoch; // path tag echoed by the cache
    logic [31:0] data; // instruction bytes, first byte in [31:24]
  } ipq_fword_t;

  // instruction length from its first byte
  function automatic logic [2:0] ipq_len(input logic java, input logic [7:0] op);
    logic [2:0] len;
    len = LEN1;
    if (!java) begin
      len = (op[7:5] == RISC_EXT_TAG) ? LEN4 : LEN2;
    end else if (op == JOP_SIPUSH) begin
      len = LEN3;
    end else if (op == JOP_BIPUSH || op == JOP_LDC) begin
      len = LEN2;
    end
    return len;
  endfunction : ipq_len
endpackage : ipq_pkg

// ===== verilog/ipq_fifo.sv
// word fifo between the instruction cache and the byte queue
// assumes same clock on both sides; valid/ready handshake on each side
`timescale 1ns/10ps
module ipq_fifo #(
  parameter int W = 33, // word width
  parameter int DEPTH = 4 // words held
) (
  input wire logic i_sys_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_in_valid, // word offered
  output logic o_in_ready, // room for a word
  input wire logic [W-1:0] i_in_data, // word in
  output logic o_out_valid, // word available
  input wire logic i_out_ready, // word taken
  output logic [W-1:0] o_out_data // oldest word
);
  localparam int PW = $clog2(DEPTH); // pointer width
  logic [W-1:0] mem [DEPTH]; // storage
  logic [PW-1:0] wr_reg; // write pointer
  logic [PW-1:0] rd_reg; // read pointer
  logic [PW:0] cnt_reg; // words held
  logic [PW:0] cnt_next; // words held next
  logic push; // word written
  logic pop; // word read

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_reg];
  assign cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);

  // pointers wrap at depth
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
    end
  end

  // flags kept in flops so the ready seen outside is registered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_in_ready <= (cnt_next != (PW+1)'(DEPTH));
      o_out_valid <= (cnt_next != '0);
    end
  end

  // storage has no reset; nothing reads an empty slot
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end
endmodule : ipq_fifo

// ===== verilog/ipq_queue.sv
// instruction prefetch queue: fetch address generation, byte queue, decode slot
// assumes the cache answers fetches in order and echoes each request's epoch,
// and that decode drives i_dec_take only while o_dec_valid is high
`timescale 1ns/10ps

// Overview of operation
// RULE1 - queue holds twelve byte entries, 96 bits
// RULE2 - risc or bytecode instructions, mixed lengths held
// RULE3 - head instruction presented to decode every cycle
// RULE4 - consume advances queue by instruction length
// RULE5 - append cache bytes whenever entries are free; the code appends a word only when all its bytes fit
// RULE6 - stall decode until whole head instruction present
// RULE7 - head always starts a complete valid instruction
// RULE8 - nonempty queue fetches only sequential words
// RULE9 - first word after flush rotated, upper bytes dropped
// RULE10 - dedicated adder makes sequential fetch addresses
// RULE11 - flush on exception, pc write, branch events
// RULE12 - empty queue, aligned target: forward word to decode
// RULE13 - halfword target goes through queue, one cycle
// RULE14 - forwarding only in risc mode, never bytecode
// RULE15 - flush empties queue, drops old path fetches
// RULE16 - risc length from opcode: compact or extended
module ipq_queue #(
  parameter int QBYTES = ipq_pkg::QB, // byte entries
  parameter int FDEPTH = ipq_pkg::FIFO_DEPTH // fetch buffer words
) (
  input wire logic i_sys_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire ipq_pkg::ipq_flush_t i_flush, // change-of-flow events
  input wire logic [31:0] i_flush_pc, // target of the change of flow
  input wire logic i_java_mode, // bytecode mode
  output logic o_fetch_req, // fetch request to cache
  output logic [31:0] o_fetch_addr, // word address of the fetch
  output logic o_fetch_epoch, // path tag of the fetch
  input wire logic i_fetch_ready, // cache took the request
  input wire logic i_icache_valid, // fetched word offered
  input wire logic [31:0] i_icache_data, // fetched word
  input wire logic i_icache_epoch, // tag echoed with the word
  output logic o_icache_ready, // room for a fetched word
  output logic o_dec_valid, // instruction presented
  output logic [31:0] o_dec_instr, // instruction, first byte in [31:24]
  output logic [2:0] o_dec_len, // instruction length in bytes
  output logic o_dec_fwd, // instruction came by forwarding
  input wire logic i_dec_take // decode consumes the instruction
);
  localparam logic [4:0] QB_C = 5'(QBYTES); // queue size at count width
  localparam logic [4:0] WB_C = 5'(ipq_pkg::WORD_BYTES); // word size at count width
  localparam logic [4:0] ROOM_C = QB_C - WB_C; // highest count that fits a word
  localparam int FW = $bits(ipq_pkg::ipq_fword_t); // fifo word width

  // byte queue, entry 0 is the head
  logic [ipq_pkg::BYTE_W-1:0] q_reg [QBYTES]; // queued bytes
  logic [ipq_pkg::BYTE_W-1:0] q_next [QBYTES]; // queued bytes next
  logic [4:0] cnt_reg; // valid bytes
  logic [4:0] cnt_next; // valid bytes next
  logic [1:0] off_reg; // bytes to drop from the next word taken
  logic epoch_reg; // current path tag
  logic [2:0] infl_reg; // fetches accepted, word not yet taken
  logic [2:0] infl_next; // outstanding next
  logic flush; // any change-of-flow event
  // fetch buffer side
  ipq_pkg::ipq_fword_t f_in; // word into the buffer
  ipq_pkg::ipq_fword_t fw; // word at buffer output
  logic f_valid; // buffer has a word
  logic f_ready; // word leaves the buffer
  logic fw_ok; // word belongs to the current path
  logic f_drop; // stale word thrown away
  // head decode
  logic [2:0] hlen; // head instruction length
  logic [2:0] flen; // forwarded instruction length
  logic hok; // head instruction complete
  logic slot_free; // decode slot may load
  logic ld_q; // slot loads from queue head
  logic fwd; // slot loads straight from the word
  logic [4:0] sh; // bytes removed from the head
  logic [4:0] c1; // bytes left after the removal
  logic [2:0] skip; // leading word bytes not appended
  logic [4:0] nb; // word bytes appended
  logic take_w; // current word consumed
  logic app; // bytes appended this cycle
  logic [31:0] wsh; // word with skipped bytes shifted out
  logic acc; // fetch request accepted
  logic pop; // buffer word consumed or dropped
  logic [5:0] pend; // bytes queued or promised

  assign flush = |i_flush; // RULE11

  // fetch words wait here so the cache sees back-pressure from the queue
  assign f_in = '{epoch: i_icache_epoch, data: i_icache_data};
  ipq_fifo #(
    .W(FW),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_icache_valid),
    .o_in_ready(o_icache_ready),
    .i_in_data(f_in),
    .o_out_valid(f_valid),
    .i_out_ready(f_ready),
    .o_out_data(fw)
  );

  // words from an abandoned path are drained without use
  always_comb begin
    fw_ok = f_valid && (fw.epoch == epoch_reg) && !flush; // RULE15
    f_drop = f_valid && !fw_ok; // RULE15
  end

  // head length: compact or extended in risc, opcode table in bytecode
  always_comb begin
    hlen = ipq_pkg::ipq_len(i_java_mode, q_reg[0]); // RULE16 RULE2
    flen = ipq_pkg::ipq_len(1'b0, fw.data[31:24]); // RULE16
    hok = (cnt_reg != '0) && (cnt_reg >= {2'h0, hlen}); // RULE6 RULE7
    slot_free = !o_dec_valid || i_dec_take;
    ld_q = slot_free && hok && !flush; // RULE3
  end

  // forwarding bypasses the queue only when the whole word is usable;
  // a halfword target still goes through the queue to keep the path short
  always_comb begin
    fwd = slot_free && (cnt_reg == '0) && fw_ok && !i_java_mode // RULE12 RULE14
      && (off_reg == ipq_pkg::ALIGN_WORD); // RULE13
  end

  // shift by the consumed length, then place the word after what is left
  always_comb begin
    sh = ld_q ? {2'h0, hlen} : '0; // RULE4
    c1 = cnt_reg - sh;
    skip = fwd ? flen : {1'b0, off_reg}; // RULE9
    nb = WB_C - {2'h0, skip};
    take_w = fw_ok && (fwd || ((c1 + nb) <= QB_C)); // RULE5
    app = take_w && (nb != '0);
    f_ready = f_drop || take_w;
    pop = f_valid && f_ready;
    wsh = fw.data << {skip, 3'h0}; // RULE9
    cnt_next = flush ? '0 : (app ? c1 + nb : c1); // RULE15
  end

  // per entry: keep a surviving byte, else take one from the word
  genvar gi;
  for (gi = 0; gi < QBYTES; gi++) begin : g_ent
    logic [4:0] src; // survivor source index
    logic [4:0] k; // word byte index
    always_comb begin
      src = 5'(gi) + sh;
      k = 5'(gi) - c1;
      q_next[gi] = q_reg[gi];
      if (src < cnt_reg) begin
        q_next[gi] = q_reg[src[3:0]]; // RULE4
      end else if (app && (5'(gi) >= c1) && (k < nb)) begin
        q_next[gi] = wsh[(WB_C - 5'h1 - k) * 5'(ipq_pkg::BYTE_W) +: ipq_pkg::BYTE_W]; // RULE5
      end
    end
  end

  // byte storage; invalid entries carry stale data that is never issued
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < QBYTES; i++) begin
        q_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < QBYTES; i++) begin
        q_reg[i] <= q_next[i]; // RULE1
      end
    end
  end

  // count and alignment of the first word on the new path
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      off_reg <= ipq_pkg::ALIGN_WORD;
    end else begin
      cnt_reg <= cnt_next; // RULE1
      if (flush) begin
        off_reg <= i_flush_pc[1:0]; // RULE9
      end else if (take_w) begin
        off_reg <= ipq_pkg::ALIGN_WORD; // RULE8
      end
    end
  end

  // path tag flips on every flush so late words can be recognised
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      epoch_reg <= 1'b0;
    end else if (flush) begin
      epoch_reg <= !epoch_reg; // RULE15
    end
  end

  // fetch credit: a request goes out only if its word is sure to fit,
  // which also keeps the word buffer from ever filling past the queue
  always_comb begin
    acc = o_fetch_req && i_fetch_ready;
    infl_next = infl_reg + 3'(acc) - 3'(pop);
    pend = {1'b0, cnt_next} + {1'b0, infl_next, 2'h0};
  end

  // outstanding count includes stale fetches until their words drain
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      infl_reg <= '0;
    end else begin
      infl_reg <= infl_next;
    end
  end

  // request holds until taken; a flush withdraws it
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fetch_req <= 1'b0;
    end else if (flush) begin
      o_fetch_req <= 1'b0; // RULE15
    end else begin
      o_fetch_req <= (o_fetch_req && !i_fetch_ready) || (pend <= {1'b0, ROOM_C}); // RULE5
    end
  end

  // sequential fetch addresses come from their own adder
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fetch_addr <= ipq_pkg::ADDR_RST;
      o_fetch_epoch <= 1'b0;
    end else if (flush) begin
      o_fetch_addr <= {i_flush_pc[31:2], ipq_pkg::ADDR_LOW0}; // RULE9
      o_fetch_epoch <= !epoch_reg; // RULE15
    end else if (acc) begin
      o_fetch_addr <= o_fetch_addr + ipq_pkg::FETCH_STEP; // RULE10 RULE8
    end
  end

  // decode slot: loads the head when complete, or the forwarded word
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dec_valid <= 1'b0;
      o_dec_instr <= '0;
      o_dec_len <= ipq_pkg::LEN0;
      o_dec_fwd <= 1'b0;
    end else if (flush) begin
      o_dec_valid <= 1'b0; // RULE15
      o_dec_fwd <= 1'b0;
    end else if (ld_q) begin
      o_dec_valid <= 1'b1; // RULE3
      o_dec_instr <= {q_reg[0], q_reg[1], q_reg[2], q_reg[3]};
      o_dec_len <= hlen; // RULE7
      o_dec_fwd <= 1'b0;
    end else if (fwd) begin
      o_dec_valid <= 1'b1; // RULE12
      o_dec_instr <= fw.data;
      o_dec_len <= flen;
      o_dec_fwd <= 1'b1;
    end else if (slot_free) begin
      o_dec_valid <= 1'b0; // RULE6
      o_dec_fwd <= 1'b0;
    end
  end
endmodule : ipq_queue

// ===== bench/ipq_icache_model.sv
// instruction cache stand-in that answers fetches of the prefetch queue
// assumes byte b of memory holds b[7:0], so every word is predictable from its address
`timescale 1ns/10ps
module ipq_icache_model (
  input wire logic i_sys_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_slow, // add wait cycles to both sides
  input wire logic i_fetch_req, // fetch request
  input wire logic [31:0] i_fetch_addr, // word address
  input wire logic i_fetch_epoch, // path tag
  output logic o_fetch_ready, // request taken
  output logic o_icache_valid, // word offered
  output logic [31:0] o_icache_data, // word, lowest address in [31:24]
  output logic o_icache_epoch, // echoed tag
  input wire logic i_icache_ready // queue took the word
);
  logic [32:0] pend[$]; // accepted requests, oldest first
  logic [32:0] head; // request being answered
  logic [1:0] wait_cnt; // paces the slow mode
  // slow mode accepts only every other cycle, so the held request is exercised
  assign o_fetch_ready = !i_slow || wait_cnt[0];
  // words come back in order; an idle data bus toggles so stale values never match
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend.delete();
      wait_cnt <= 2'h0;
      o_icache_valid <= 1'b0;
      o_icache_epoch <= 1'b0;
      o_icache_data <= 32'h5A5A_5A5A;
    end else begin
      if (i_fetch_req && o_fetch_ready) pend.push_back({i_fetch_epoch, i_fetch_addr});
      wait_cnt <= wait_cnt + 2'h1;
      if (!o_icache_valid || i_icache_ready) begin
        if (pend.size() > 0 && (!i_slow || wait_cnt == 2'h3)) begin
          head = pend.pop_front();
          o_icache_valid <= 1'b1;
          o_icache_epoch <= head[32];
          o_icache_data <= {head[7:0], head[7:0] + 8'h1, head[7:0] + 8'h2, head[7:0] + 8'h3};
        end else begin
          o_icache_valid <= 1'b0;
          o_icache_data <= ~o_icache_data;
          o_icache_epoch <= ~o_icache_epoch;
        end
      end
    end
  end
endmodule : ipq_icache_model

// ===== bench/ipq_queue_sva.sv
// port checker for the instruction prefetch queue
// assumes it is bound to ipq_queue and sees only that module's ports
`timescale 1ns/10ps
module ipq_queue_sva #(
  parameter int QBYTES = 12, // byte entries
  parameter int FDEPTH = 4 // fetch buffer words
) (
  input wire logic i_sys_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire ipq_pkg::ipq_flush_t i_flush, // change-of-flow events
  input wire logic [31:0] i_flush_pc, // flush target
  input wire logic i_java_mode, // bytecode mode
  input wire logic o_fetch_req, // fetch request
  input wire logic [31:0] o_fetch_addr, // fetch address
  input wire logic o_fetch_epoch, // fetch tag
  input wire logic i_fetch_ready, // request taken
  input wire logic i_icache_valid, // word offered
  input wire logic [31:0] i_icache_data, // word
  input wire logic i_icache_epoch, // echoed tag
  input wire logic o_icache_ready, // word room
  input wire logic o_dec_valid, // instruction presented
  input wire logic [31:0] o_dec_instr, // instruction
  input wire logic [2:0] o_dec_len, // length
  input wire logic o_dec_fwd, // forwarded
  input wire logic i_dec_take // consumed
);
  logic any_flush; // some change-of-flow event this cycle
  assign any_flush = |i_flush;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_fetch_align: assert property (o_fetch_req |-> o_fetch_addr[1:0] == ipq_pkg::ADDR_LOW0)
    else $error("fetch address not word aligned");
  a_fetch_hold: assert property (o_fetch_req && !i_fetch_ready && !any_flush |=>
    o_fetch_req && $stable(o_fetch_addr) && $stable(o_fetch_epoch))
    else $error("fetch request changed before taken");
  a_fetch_seq: assert property ((o_fetch_req && i_fetch_ready && !any_flush) ##1 o_fetch_req
    |-> o_fetch_addr == $past(o_fetch_addr) + 32'h4)
    else $error("fetch address not sequential");
  a_flush_empty: assert property (any_flush |=> !o_dec_valid)
    else $error("instruction presented after flush");
  a_dec_hold: assert property (o_dec_valid && !i_dec_take && !any_flush |=>
    o_dec_valid && $stable(o_dec_instr) && $stable(o_dec_len))
    else $error("presented instruction not held");
  a_len_risc: assert property (o_dec_valid && !i_java_mode && $stable(i_java_mode) |->
    o_dec_len == ((o_dec_instr[31:29] == 3'h7) ? 3'h4 : 3'h2))
    else $error("risc length wrong");
  a_len_java: assert property (o_dec_valid && i_java_mode && $stable(i_java_mode) |->
    o_dec_len == ((o_dec_instr[31:24] == 8'h11) ? 3'h3 :
    (o_dec_instr[31:24] == 8'h10 || o_dec_instr[31:24] == 8'h12) ? 3'h2 : 3'h1))
    else $error("bytecode length wrong");
  a_fwd_mode: assert property (o_dec_valid && o_dec_fwd |-> !i_java_mode)
    else $error("forwarding in bytecode mode");
endmodule : ipq_queue_sva
bind ipq_queue ipq_queue_sva #(.QBYTES(QBYTES), .FDEPTH(FDEPTH)) i_sva (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_flush(i_flush), .i_flush_pc(i_flush_pc),
  .i_java_mode(i_java_mode), .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
  .o_fetch_epoch(o_fetch_epoch), .i_fetch_ready(i_fetch_ready), .i_icache_valid(i_icache_valid),
  .i_icache_data(i_icache_data), .i_icache_epoch(i_icache_epoch), .o_icache_ready(o_icache_ready),
  .o_dec_valid(o_dec_valid), .o_dec_instr(o_dec_instr), .o_dec_len(o_dec_len),
  .o_dec_fwd(o_dec_fwd), .i_dec_take(i_dec_take));

// ===== bench/instruction_prefetch_queue_test.sv
// self-checking bench for the instruction prefetch queue with a cache model
// assumes memory byte b holds b[7:0]; decode is played by the bench
`timescale 1ns/10ps
module instruction_prefetch_queue_test;
  typedef struct { logic [31:0] pc; logic java; int n; } ipq_row_t; // flush target and run
  logic i_sys_clk, i_rst_n, i_java_mode, i_fetch_ready, i_icache_valid, i_icache_epoch;
  logic i_dec_take, slow, o_fetch_req, o_fetch_epoch, o_icache_ready, o_dec_valid, o_dec_fwd;
  ipq_pkg::ipq_flush_t i_flush; // event pulses
  logic [31:0] i_flush_pc, i_icache_data, o_fetch_addr, o_dec_instr;
  logic [2:0] o_dec_len;
  int bad_count = 0;
  int compares = 0;
  int lat[7]; // cycles to first instruction per row
  ipq_row_t rows[7] = '{'{32'h100, 1'b0, 6}, '{32'h102, 1'b0, 6}, '{32'h100, 1'b1, 6},
    '{32'h10F, 1'b1, 6}, '{32'h111, 1'b1, 4}, '{32'h0E0, 1'b0, 5}, '{32'h1FA, 1'b0, 4}};
  ipq_queue i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_flush(i_flush),
    .i_flush_pc(i_flush_pc), .i_java_mode(i_java_mode), .o_fetch_req(o_fetch_req),
    .o_fetch_addr(o_fetch_addr), .o_fetch_epoch(o_fetch_epoch), .i_fetch_ready(i_fetch_ready),
    .i_icache_valid(i_icache_valid), .i_icache_data(i_icache_data),
    .i_icache_epoch(i_icache_epoch), .o_icache_ready(o_icache_ready), .o_dec_valid(o_dec_valid),
    .o_dec_instr(o_dec_instr), .o_dec_len(o_dec_len), .o_dec_fwd(o_dec_fwd),
    .i_dec_take(i_dec_take));
  ipq_icache_model i_cache (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .i_fetch_req(o_fetch_req), .i_fetch_addr(o_fetch_addr), .i_fetch_epoch(o_fetch_epoch),
    .o_fetch_ready(i_fetch_ready), .o_icache_valid(i_icache_valid),
    .o_icache_data(i_icache_data), .o_icache_epoch(i_icache_epoch),
    .i_icache_ready(o_icache_ready));
  // 200 MHz core clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_len(input string what, input logic [2:0] exp, input logic [2:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_len
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // length worked out independently of the design's decoder
  function automatic logic [2:0] exp_len(input logic java, input logic [7:0] b);
    if (!java) return (b >= 8'hE0) ? 3'h4 : 3'h2;
    return (b == 8'h11) ? 3'h3 : (b == 8'h10 || b == 8'h12) ? 3'h2 : 3'h1;
  endfunction : exp_len
  // idle first lets outstanding fetches land, so first-instruction latency is repeatable
  task automatic do_flush(input logic [31:0] pc, input logic java, input int kind, input int idle);
    repeat (idle) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    i_flush <= 5'h10 >> (kind % 5);
    i_flush_pc <= pc;
    @(posedge i_sys_clk);
    i_flush <= '0;
    // mode moves only once the flush has emptied the slot, so an old
    // forwarded instruction is never seen under the new mode
    i_java_mode <= java;
  endtask : do_flush
  // consume n instructions from pc0, checking bytes, length and forwarding
  task automatic run_seq(input logic [31:0] pc0, input logic java, input int n, output int first);
    logic [31:0] pc;
    logic [31:0] m;
    logic [2:0] len;
    int w;
    pc = pc0;
    first = 0;
    for (int k = 0; k < n; k++) begin
      w = 0;
      #1;
      while (o_dec_valid !== 1'b1 && w < 40) begin
        @(posedge i_sys_clk);
        #1;
        w++;
      end
      if (k == 0) first = w;
      len = exp_len(java, pc[7:0]);
      m = ~(32'hFFFF_FFFF >> (8 * len));
      chk_bit("valid", 1'b1, o_dec_valid);
      chk_word("instr", {pc[7:0], pc[7:0] + 8'h1, pc[7:0] + 8'h2, pc[7:0] + 8'h3} & m, o_dec_instr & m);
      chk_len("len", len, o_dec_len);
      if (k == 0 || java) chk_bit("fwd", !java && pc0[1:0] == 2'h0, o_dec_fwd);
      @(posedge i_sys_clk) i_dec_take <= 1'b1;
      @(posedge i_sys_clk) i_dec_take <= 1'b0;
      pc = pc + len;
    end
  endtask : run_seq
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // cuts a hang short; the tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    $display("ERROR watchdog expected done seen timeout");
    wrap_up();
  end
  // reset, table of flush rows, then stall, mid-stream flush and slow cache
  initial begin
    int d;
    i_rst_n = 1'b0;
    i_flush = '0;
    i_flush_pc = 32'h0;
    i_java_mode = 1'b0;
    i_dec_take = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    #1;
    chk_bit("reset req", 1'b0, o_fetch_req);
    chk_bit("reset valid", 1'b0, o_dec_valid);
    chk_bit("reset ready", 1'b1, o_icache_ready);
    @(posedge i_sys_clk) i_rst_n <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      do_flush(rows[r].pc, rows[r].java, r, 10);
      run_seq(rows[r].pc, rows[r].java, rows[r].n, lat[r]);
    end
    chk_word("halfword delay", lat[0] + 1, lat[1]);
    chk_word("bytecode delay", lat[0] + 1, lat[2]);
    do_flush(32'h100, 1'b0, 1, 10);
    repeat (30) @(posedge i_sys_clk);
    #1;
    chk_bit("full no fetch", 1'b0, o_fetch_req);
    run_seq(32'h100, 1'b0, 12, d);
    slow <= 1'b1;
    do_flush(32'h300, 1'b0, 0, 0);
    run_seq(32'h300, 1'b0, 2, d);
    do_flush(32'h402, 1'b1, 3, 0);
    run_seq(32'h402, 1'b1, 5, d);
    do_flush(32'h204, 1'b0, 4, 0);
    run_seq(32'h204, 1'b0, 6, d);
    wrap_up();
  end
endmodule : instruction_prefetch_queue_test
